/* sim/crf_flags_bench.sv */
// Bench for the roll-over flag bank: a table of wrap events, then hand tests.
// Assumes crf_pkg and crf_flags are compiled first; this bench is the Avalon master.
`timescale 1ns/100ps
module crf_flags_bench;
import crf_pkg::*;
typedef struct {logic alm; logic cc; logic [12:0] ev; logic [15:0] ex;} crf_row_t;
localparam logic [9:0] a_par = {CRF_IDX_PARITY, 2'h0};
localparam logic [9:0] a_alm = {CRF_IDX_ALARM, 2'h0};
localparam logic [9:0] a_mode = {CRF_IDX_MODE, 2'h0};
logic clk = 1'h0;
logic reset = 1'h1;
logic avs_read = 1'h0, avs_write = 1'h0;
logic [9:0] avs_address = 10'h000;
logic [31:0] avs_writedata = 32'h0;
logic [31:0] avs_readdata;
logic [31:0] rd;
logic [3:0] avs_byteenable = 4'hf;
logic avs_waitrequest, concat_mode;
logic [9:0] parity_wrap_evt = 10'h000;
logic [12:0] alarm_wrap_evt = 13'h0000;
int fail_count = 0;
int total_checks = 0;
int cyc = 0;
crf_row_t rows[8];
crf_flags dut (
    .clk(clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .parity_wrap_evt(parity_wrap_evt), .alarm_wrap_evt(alarm_wrap_evt),
    .concat_mode(concat_mode));
always #5 clk = ~clk;
// Whole run needs well under a thousand cycles
always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
        fail_count++;
        results();
    end
end
////////////////////////////////////////
task results;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
        $display("*** PASS ***");
    else
        $display("*** FAIL ***");
    $finish;
endtask
task chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
        fail_count++;
        $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
endtask
// Optional wrap pulse lands on the accepting edge of the transfer
task bus(input logic w, input logic [9:0] a, input logic [31:0] d, input logic [9:0] pe);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !w;
    avs_write <= w;
    do begin
        @(posedge clk);
        parity_wrap_evt <= (avs_waitrequest !== 1'h0) ? pe : 10'h000;
    end while (avs_waitrequest !== 1'h0);
    rd = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
endtask
task wr(input logic [9:0] a, input logic [31:0] d);
    bus(1'h1, a, d, 10'h000);
endtask
task rdx(input logic [9:0] a, input logic [31:0] e);
    bus(1'h0, a, 32'h0, 10'h000);
    chk(rd, e);
endtask
task pulse(input logic alm, input logic [12:0] ev);
    @(posedge clk);
    alarm_wrap_evt <= alm ? ev : 13'h0000;
    parity_wrap_evt <= alm ? 10'h000 : ev[9:0];
    @(posedge clk);
    alarm_wrap_evt <= 13'h0000;
    parity_wrap_evt <= 10'h000;
endtask
////////////////////////////////////////
initial begin
    rows = '{'{1'h0, 1'h0, 13'h0001, 16'h0001}, '{1'h0, 1'h0, 13'h0002, 16'h0002},
             '{1'h0, 1'h0, 13'h0004, 16'h0004}, '{1'h0, 1'h0, 13'h0008, 16'h0008},
             '{1'h0, 1'h0, 13'h0010, 16'h0010}, '{1'h0, 1'h1, 13'h003f, 16'h0007},
             '{1'h1, 1'h0, 13'h1c00, 16'h1c00}, '{1'h1, 1'h1, 13'h1e01, 16'h0201}};
    repeat (6) @(posedge clk);
    reset <= 1'h0;
    foreach (rows[i]) begin
        wr(a_mode, {31'h0, rows[i].cc});
        pulse(rows[i].alm, rows[i].ev);
        rdx(rows[i].alm ? a_alm : a_par, {16'h0, rows[i].ex});
        chk({31'h0, concat_mode}, {31'h0, rows[i].cc});
        wr(rows[i].alm ? a_alm : a_par, 32'h0);
        rdx(rows[i].alm ? a_alm : a_par, 32'h0);
        $display("row %0d done", i);
    end
    pulse(1'h0, 13'h0004);
    repeat (20) @(posedge clk);
    rdx(a_par, 32'h4);
    rdx(a_par, 32'h4);
    $display("sticky test done");
    // Clear of bit 2 meets a fresh bit 0 wrap on the same edge
    bus(1'h1, a_par, 32'h0, 10'h001);
    rdx(a_par, 32'h1);
    $display("wrap against clear test done");
    wr(a_par, 32'hffff_ffff);
    rdx(a_par, 32'h3ff);
    wr(a_alm, 32'hffff_ffff);
    rdx(a_alm, 32'h1fff);
    avs_byteenable <= 4'h2;
    wr(a_alm, 32'h0);
    avs_byteenable <= 4'hf;
    rdx(a_alm, 32'hff);
    wr(10'h200, 32'hffff);
    rdx(10'h200, 32'h0);
    $display("access test done");
    reset <= 1'h1;
    repeat (6) @(posedge clk);
    reset <= 1'h0;
    @(posedge clk);
    chk({31'h0, concat_mode}, 32'h0);
    rdx(a_par, 32'h0);
    rdx(a_alm, 32'h0);
    rdx(a_mode, 32'h0);
    $display("reset test done");
    results();
end
endmodule

/* src/crf_flags.sv */
// Sticky roll-over flag bank for the receive error and alarm counters.
// Assumes wrap pulses synchronous to clk, one cycle per counter wrap.
`timescale 1ns/100ps
module crf_flags
    import crf_pkg::*;
(
    input wire logic clk, // 100 MHz system clock
    input wire logic reset, // Synchronous, active high
    input wire logic [crf_pkg::CRF_ADDR_W-1:0] avs_address, // Byte address
    input wire logic avs_read, // Read request
    input wire logic avs_write, // Write request
    input wire logic [crf_pkg::CRF_DATA_W-1:0] avs_writedata, // Write data
    input wire logic [3:0] avs_byteenable, // Byte lanes of the write
    output logic [crf_pkg::CRF_DATA_W-1:0] avs_readdata, // Read data
    output logic avs_waitrequest, // Low for the accepting cycle
    input wire logic [crf_pkg::CRF_PAR_EVT_W-1:0] parity_wrap_evt, // Parity counter wraps
    input wire logic [crf_pkg::CRF_ALM_EVT_W-1:0] alarm_wrap_evt, // Alarm counter wraps
    output logic concat_mode // Concatenated mode selected
);
    import crf_pkg::*;

    typedef struct packed {
        logic [15:0] parity;
        logic [15:0] alarm;
        logic concat;
        logic wait_n;
        logic [31:0] rdata;
    } crf_state_t;

    crf_state_t st_ff;
    crf_state_t nxt_st;

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // Events the current mode lets through
    function automatic logic [15:0] accepted(input logic [15:0] evt,
                                             input logic [15:0] impl,
                                             input logic [15:0] four_only,
                                             input logic concat);
        logic [15:0] m;
        m = impl;
        if (concat) begin
            m = impl & ~four_only;
        end
        return evt & m;
    endfunction

    function automatic logic hits(input logic [CRF_ADDR_W-1:0] addr, input logic [7:0] idx);
        return (addr[1:0] == 2'h0) && (addr[CRF_ADDR_W-1:2] == idx);
    endfunction

    // Byte-lane merge of a 16-bit register
    function automatic logic [15:0] merged(input logic [15:0] cur, input logic [31:0] wd,
                                           input logic [3:0] be);
        logic [15:0] v;
        v = cur;
        if (be[0]) begin
            v[7:0] = wd[7:0];
        end
        if (be[1]) begin
            v[15:8] = wd[15:8];
        end
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Bus decode

    logic take;
    logic wr_par;
    logic wr_alm;
    logic wr_mode;
    logic [15:0] par_evt;
    logic [15:0] alm_evt;

    // A request is taken on the edge where waitrequest is seen low
    assign take = (avs_read | avs_write) & st_ff.wait_n;
    assign wr_par = take & avs_write & hits(avs_address, CRF_IDX_PARITY);
    assign wr_alm = take & avs_write & hits(avs_address, CRF_IDX_ALARM);
    assign wr_mode = take & avs_write & hits(avs_address, CRF_IDX_MODE);
    assign par_evt = accepted({6'h00, parity_wrap_evt}, CRF_PAR_IMPL, CRF_PAR_FOUR_ONLY,
                              st_ff.concat);
    assign alm_evt = accepted({3'h0, alarm_wrap_evt}, CRF_ALM_IMPL, CRF_ALM_FOUR_ONLY,
                              st_ff.concat);

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        nxt_st = st_ff;
        // One wait cycle, then one accepting cycle
        nxt_st.wait_n = 1'b0;
        if ((avs_read | avs_write) && !st_ff.wait_n) begin
            nxt_st.wait_n = 1'b1;
        end
        if ((avs_read | avs_write) && !st_ff.wait_n) begin
            // Read data frozen a cycle early; unmapped reads return zero
            nxt_st.rdata = CRF_RDATA_RESET;
            if (hits(avs_address, CRF_IDX_PARITY)) begin
                nxt_st.rdata = {16'h0000, st_ff.parity};
            end else if (hits(avs_address, CRF_IDX_ALARM)) begin
                nxt_st.rdata = {16'h0000, st_ff.alarm};
            end else if (hits(avs_address, CRF_IDX_MODE)) begin
                nxt_st.rdata = {31'h0, st_ff.concat};
            end
        end
        if (wr_par) begin
            nxt_st.parity = merged(st_ff.parity, avs_writedata, avs_byteenable) & CRF_PAR_IMPL;
        end
        if (wr_alm) begin
            nxt_st.alarm = merged(st_ff.alarm, avs_writedata, avs_byteenable) & CRF_ALM_IMPL;
        end
        if (wr_mode && avs_byteenable[0]) begin
            nxt_st.concat = avs_writedata[CRF_MODE_CONCAT];
        end
        // Hardware set is applied after the bus writes, with only reset after it, so it wins over a clear
        nxt_st.parity = nxt_st.parity | par_evt;
        nxt_st.alarm = nxt_st.alarm | alm_evt;
        if (reset) begin
            nxt_st.parity = CRF_FLAG_RESET;
            nxt_st.alarm = CRF_FLAG_RESET;
            nxt_st.concat = CRF_MODE_RESET;
            nxt_st.wait_n = 1'b0;
            nxt_st.rdata = CRF_RDATA_RESET;
        end
    end

    always_ff @(posedge clk) begin
        st_ff <= nxt_st;
    end

    assign avs_readdata = st_ff.rdata;
    assign avs_waitrequest = ~st_ff.wait_n;
    assign concat_mode = st_ff.concat;

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // A request waits one cycle, is taken once, then the slave waits again
    sequence s_req_waiting;
        (avs_read | avs_write) && avs_waitrequest;
    endsequence

    sequence s_one_accept;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence

    property p_take_one_cycle;
        s_req_waiting |-> ##1 s_one_accept;
    endproperty
    a_take_one_cycle: assert property (p_take_one_cycle) else $error("waitrequest timing wrong");

    property p_chan2_b3;
        parity_wrap_evt[CRF_CHAN2_B3_WRAP] && !st_ff.concat |=> st_ff.parity[CRF_CHAN2_B3_WRAP];
    endproperty
    a_chan2_b3: assert property (p_chan2_b3) else $error("chan2 b3 flag not set");

    property p_chan1_b3;
        parity_wrap_evt[CRF_CHAN1_B3_WRAP] && !st_ff.concat |=> st_ff.parity[CRF_CHAN1_B3_WRAP];
    endproperty
    a_chan1_b3: assert property (p_chan1_b3) else $error("chan1 b3 flag not set");

    property p_chan0_b3;
        parity_wrap_evt[CRF_CHAN0_B3_WRAP] |=> st_ff.parity[CRF_CHAN0_B3_WRAP];
    endproperty
    a_chan0_b3: assert property (p_chan0_b3) else $error("chan0 b3 flag not set");

    property p_line_parity;
        parity_wrap_evt[CRF_LINE_PARITY_WRAP] |=> st_ff.parity[CRF_LINE_PARITY_WRAP];
    endproperty
    a_line_parity: assert property (p_line_parity) else $error("line parity flag not set");

    property p_section_parity;
        parity_wrap_evt[CRF_SECTION_PARITY_WRAP] |=> st_ff.parity[CRF_SECTION_PARITY_WRAP];
    endproperty
    a_section_parity: assert property (p_section_parity) else $error("section flag not set");

    property p_sticky;
        st_ff.parity[CRF_CHAN0_B3_WRAP] && !wr_par |=> st_ff.parity[CRF_CHAN0_B3_WRAP];
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag cleared by hardware");

    property p_concat_ignore;
        st_ff.concat && !wr_alm && !st_ff.alarm[CRF_CHAN1_LABEL_MISMATCH_WRAP]
            |=> !st_ff.alarm[CRF_CHAN1_LABEL_MISMATCH_WRAP];
    endproperty
    a_concat_ignore: assert property (p_concat_ignore) else $error("four-channel flag set in concat");

    property p_concat_keep;
        st_ff.concat && alarm_wrap_evt[CRF_CHAN0_LABEL_MISMATCH_WRAP]
            |=> st_ff.alarm[CRF_CHAN0_LABEL_MISMATCH_WRAP];
    endproperty
    a_concat_keep: assert property (p_concat_keep) else $error("channel 0 flag lost in concat");

    property p_alarm_write;
        wr_alm && avs_byteenable[1:0] == 2'h3 && alarm_wrap_evt == '0
            |=> st_ff.alarm == ($past(avs_writedata[15:0]) & CRF_ALM_IMPL);
    endproperty
    a_alarm_write: assert property (p_alarm_write) else $error("alarm write not stored");

    property p_parity_reset;
        disable iff (1'b0) reset |=> st_ff.parity == CRF_FLAG_RESET && st_ff.alarm == CRF_FLAG_RESET;
    endproperty
    a_parity_reset: assert property (p_parity_reset) else $error("flags not zero after reset");

    property p_label_mismatch;
        alarm_wrap_evt[CRF_CHAN3_LABEL_MISMATCH_WRAP] && !st_ff.concat
            |=> st_ff.alarm[CRF_CHAN3_LABEL_MISMATCH_WRAP];
    endproperty
    a_label_mismatch: assert property (p_label_mismatch) else $error("chan3 mismatch flag not set");

    property p_set_wins;
        wr_par && avs_byteenable[0] && !avs_writedata[CRF_SECTION_PARITY_WRAP]
            && parity_wrap_evt[CRF_SECTION_PARITY_WRAP] |=> st_ff.parity[CRF_SECTION_PARITY_WRAP];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("wrap lost to clear");

    property p_chan2_label;
        alarm_wrap_evt[CRF_CHAN2_LABEL_MISMATCH_WRAP] && !st_ff.concat
            |=> st_ff.alarm[CRF_CHAN2_LABEL_MISMATCH_WRAP];
    endproperty
    a_chan2_label: assert property (p_chan2_label) else $error("chan2 mismatch flag not set");

    property p_chan1_label;
        alarm_wrap_evt[CRF_CHAN1_LABEL_MISMATCH_WRAP] && !st_ff.concat
            |=> st_ff.alarm[CRF_CHAN1_LABEL_MISMATCH_WRAP];
    endproperty
    a_chan1_label: assert property (p_chan1_label) else $error("chan1 mismatch flag not set");

    property p_b3_concat_ignore;
        st_ff.concat && !wr_par && !st_ff.parity[CRF_CHAN1_B3_WRAP]
            |=> !st_ff.parity[CRF_CHAN1_B3_WRAP];
    endproperty
    a_b3_concat_ignore: assert property (p_b3_concat_ignore) else $error("chan1 b3 set in concat");

    property p_line_concat;
        st_ff.concat && parity_wrap_evt[CRF_LINE_PARITY_WRAP] |=> st_ff.parity[CRF_LINE_PARITY_WRAP];
    endproperty
    a_line_concat: assert property (p_line_concat) else $error("line flag lost in concat");

    property p_section_concat;
        st_ff.concat && parity_wrap_evt[CRF_SECTION_PARITY_WRAP] |=> st_ff.parity[CRF_SECTION_PARITY_WRAP];
    endproperty
    a_section_concat: assert property (p_section_concat) else $error("section flag lost in concat");

    // Whole register checked; only a bus write may drop a bit
    property p_alarm_sticky;
        !wr_alm |=> (st_ff.alarm & $past(st_ff.alarm)) == $past(st_ff.alarm);
    endproperty
    a_alarm_sticky: assert property (p_alarm_sticky) else $error("alarm flag cleared by hardware");

    property p_parity_write;
        wr_par && avs_byteenable[1:0] == 2'h3 && parity_wrap_evt == '0
            |=> st_ff.parity == ($past(avs_writedata[15:0]) & CRF_PAR_IMPL);
    endproperty
    a_parity_write: assert property (p_parity_write) else $error("parity write not stored");

    // Data captured in the waiting cycle, so a wrap in the accepting cycle shows next read
    property p_read_parity;
        avs_read && avs_waitrequest && hits(avs_address, CRF_IDX_PARITY)
            |=> avs_readdata == {16'h0000, $past(st_ff.parity)};
    endproperty
    a_read_parity: assert property (p_read_parity) else $error("parity read data wrong");

    property p_read_alarm;
        avs_read && avs_waitrequest && hits(avs_address, CRF_IDX_ALARM)
            |=> avs_readdata == {16'h0000, $past(st_ff.alarm)};
    endproperty
    a_read_alarm: assert property (p_read_alarm) else $error("alarm read data wrong");

    property p_wait_idle;
        !(avs_read | avs_write) |=> avs_waitrequest;
    endproperty
    a_wait_idle: assert property (p_wait_idle) else $error("waitrequest low without a request");

    property p_upper_zero;
        avs_readdata[31:16] == 16'h0000;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("read data upper half not zero");

    property p_unimpl_zero;
        st_ff.parity[15:10] == 6'h00 && st_ff.alarm[15:13] == 3'h0;
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented flag bit set");

    property p_mode_write;
        wr_mode && avs_byteenable[0] |=> concat_mode == $past(avs_writedata[CRF_MODE_CONCAT]);
    endproperty
    a_mode_write: assert property (p_mode_write) else $error("mode write not stored");

endmodule

/* src/crf_pkg.sv */
// Package for the counter roll-over flag bank: offsets, field masks, resets.
// Assumes a byte-addressed Avalon-MM slave with 32-bit data, one word per register.
package crf_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] CRF_IDX_PARITY = 8'h52;
    localparam logic [7:0] CRF_IDX_ALARM = 8'h53;
    localparam logic [7:0] CRF_IDX_MODE = 8'h54;
    localparam int CRF_ADDR_W = 10;
    localparam int CRF_DATA_W = 32;
    localparam int CRF_REG_W = 16;
    localparam int CRF_PAR_EVT_W = 10;
    localparam int CRF_ALM_EVT_W = 13;

    // Parity roll-over field positions
    localparam int CRF_SECTION_PARITY_WRAP = 0;
    localparam int CRF_LINE_PARITY_WRAP = 1;
    localparam int CRF_CHAN0_B3_WRAP = 2;
    localparam int CRF_CHAN1_B3_WRAP = 3;
    localparam int CRF_CHAN2_B3_WRAP = 4;
    localparam int CRF_CHAN3_B3_WRAP = 5;
    localparam int CRF_CHAN0_TEST_WRAP = 6;

    // Alarm roll-over field positions
    localparam int CRF_LINE_FAR_BLOCK_WRAP = 0;
    localparam int CRF_CHAN0_DISCARD_WRAP = 1;
    localparam int CRF_CHAN3_DISCARD_WRAP = 4;
    localparam int CRF_CHAN0_FAR_BLOCK_WRAP = 5;
    localparam int CRF_CHAN3_FAR_BLOCK_WRAP = 8;
    localparam int CRF_CHAN0_LABEL_MISMATCH_WRAP = 9;
    localparam int CRF_CHAN1_LABEL_MISMATCH_WRAP = 10;
    localparam int CRF_CHAN2_LABEL_MISMATCH_WRAP = 11;
    localparam int CRF_CHAN3_LABEL_MISMATCH_WRAP = 12;

    // Implemented bits and bits that only count in four-channel mode
    localparam logic [15:0] CRF_PAR_IMPL = 16'h03ff;
    localparam logic [15:0] CRF_PAR_FOUR_ONLY = 16'h03b8;
    localparam logic [15:0] CRF_ALM_IMPL = 16'h1fff;
    localparam logic [15:0] CRF_ALM_FOUR_ONLY = 16'h1ddc;
    localparam logic [15:0] CRF_FLAG_RESET = 16'h0000;

    // Mode register: bit 0 set selects concatenated single-channel mode
    localparam int CRF_MODE_CONCAT = 0;
    localparam logic CRF_MODE_RESET = 1'b0;
    localparam logic [31:0] CRF_RDATA_RESET = 32'h0000_0000;
endpackage
